// ===== scr_pkg.sv
// Package of constants for the serial configuration register bank.
// Assumes a 10 MHz system clock and a four-wire serial host.
package scr_pkg;

    // Frame layout: one direction bit, fifteen address bits, then bytes
    localparam int unsigned ADDR_W      = 15;             // Register address width
    localparam int unsigned HDR_BITS    = 16;             // Header length in bits
    localparam int unsigned BYTE_BITS   = 8;              // Data unit length
    localparam int unsigned CNT_W       = 5;              // Bit counter width

    // Register offsets
    localparam logic [14:0] OFS_SETUP   = 15'h0000;       // interface_setup
    localparam logic [14:0] OFS_POWER   = 15'h0002;       // power_state
    localparam logic [14:0] OFS_CLASS   = 15'h0003;       // device_class
    localparam logic [14:0] OFS_USER    = 15'h0010;       // user_config (address hold)
    localparam logic [14:0] OFS_GAIN0   = 15'h0360;       // bank0_fine_gain
    localparam logic [14:0] OFS_GAIN1   = 15'h0361;       // bank1_fine_gain
    localparam logic [14:0] OFS_GAIN4   = 15'h0364;       // bank4_fine_gain
    localparam logic [14:0] OFS_GAIN5   = 15'h0365;       // bank5_fine_gain

    // Field positions
    localparam int unsigned SETUP_RST_BIT  = 7;           // Full reset request
    localparam int unsigned SETUP_ASC_BIT  = 5;           // Address direction
    localparam int unsigned SETUP_SDO_BIT  = 4;           // separate_output_flag
    localparam int unsigned USER_HOLD_BIT  = 0;           // Address hold

    // Reset values and fixed fields
    localparam logic [7:0]  SETUP_RESET    = 8'h30;       // interface_setup default
    localparam logic [7:0]  SETUP_RW_MASK  = 8'h6F;       // Bits that store writes
    localparam logic [7:0]  POWER_RESET    = 8'h00;       // power_state default
    localparam logic [7:0]  CLASS_RW_MASK  = 8'hF0;       // Upper bits store writes
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;       // Cleared byte
    localparam logic [1:0]  PWR_NORMAL     = 2'h0;        // Normal operation
    localparam logic [1:0]  PWR_DOWN       = 2'h3;        // Power-down

    // Full reset settle time
    localparam int unsigned CLK_PERIOD_NS  = 100;         // System clock period
    localparam int unsigned SRST_TIME_NS   = 750;         // Longest reset duration
    localparam int unsigned SRST_CYCLES    =
        (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;   // Rounded up
    localparam int unsigned SRST_W         = 4;           // Reset counter width

endpackage : scr_pkg

// ===== scr_spi_shift.sv
// Serial frame shifter for the configuration register bank.
// Assumes serial pins synchronous to clock, each serial clock half
// period at least three system clocks long.
`timescale 1ns/10ps
`default_nettype none
module scr_spi_shift
    import scr_pkg::*;
(
    input  wire logic              clock,       // System clock
    input  wire logic              rst_b,       // Async reset, active low
    input  wire logic              clear,       // Abort frame (soft reset)
    input  wire logic              sclk,        // Serial clock pin
    input  wire logic              cs_b,        // Chip select, active low
    input  wire logic              sdi,         // Serial data in
    output logic                   sdo,         // Serial data out
    output logic                   hdr_valid,   // Header complete pulse
    output logic                   hdr_read,    // Header direction, 1 = read
    output logic [ADDR_W-1:0]      hdr_addr,    // Header start address
    output logic                   byte_valid,  // Data byte complete pulse
    output logic [7:0]             byte_data,   // Received data byte
    input  wire logic [7:0]        rd_data      // Byte to send next
);

    logic              sclk_q, sclk_d;           // Previous serial clock level
    logic [CNT_W-1:0]  cnt_q, cnt_d;             // Bits since header or byte start
    logic              data_q, data_d;           // Past the header
    logic [15:0]       rx_q, rx_d;               // Receive shift register
    logic [7:0]        tx_q, tx_d;               // Transmit shift register
    logic              load_q, load_d;           // Load tx one cycle after a boundary
    logic              rise;                     // Serial clock rising edge

    assign rise       = sclk & ~sclk_q & ~cs_b;
    assign sdo        = tx_q[7];
    assign hdr_read   = rx_q[15];
    assign hdr_addr   = rx_q[ADDR_W-1:0];
    assign byte_data  = rx_q[7:0];
    assign hdr_valid  = ~data_q & (cnt_q == CNT_W'(HDR_BITS));
    assign byte_valid = data_q & (cnt_q == CNT_W'(BYTE_BITS));

    // Next state of the shifter
    always_comb begin
        sclk_d = sclk;
        cnt_d  = cnt_q;
        data_d = data_q;
        rx_d   = rx_q;
        tx_d   = tx_q;
        load_d = hdr_valid | byte_valid;
        if (clear | cs_b) begin
            // Frame idle or aborted
            cnt_d  = '0;
            data_d = 1'b0;
            load_d = 1'b0;
            tx_d   = BYTE_ZERO;
        end else begin
            if (hdr_valid | byte_valid) begin
                // Boundary consumed, start a new byte
                cnt_d  = '0;
                data_d = 1'b1;
            end
            if (rise) begin
                // Sample input, shift output after host sampled it
                rx_d  = {rx_q[14:0], sdi};
                cnt_d = cnt_d + CNT_W'(1);
                tx_d  = {tx_q[6:0], 1'b0};
            end
            if (load_q) begin
                // Read data of the current address
                tx_d = rd_data;
            end
        end
    end

    // Shifter registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            cnt_q  <= '0;
            data_q <= 1'b0;
            rx_q   <= '0;
            tx_q   <= BYTE_ZERO;
            load_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
            cnt_q  <= cnt_d;
            data_q <= data_d;
            rx_q   <= rx_d;
            tx_q   <= tx_d;
            load_q <= load_d;
        end
    end

endmodule : scr_spi_shift
`default_nettype wire

// ===== scr_regs.sv
// Core configuration register bank reached over a four-wire serial port.
// Assumes serial pins synchronous to clock and fuse values stable.
`timescale 1ns/10ps
`default_nettype none
module scr_regs
    import scr_pkg::*;
#(
    parameter logic [3:0] CLASS_CODE = 4'h6    // Class code, value arbitrary
)(
    input  wire logic        clock,        // System clock, 10 MHz
    input  wire logic        rst_b,        // Async reset, active low
    input  wire logic        sclk,         // Serial clock
    input  wire logic        cs_b,         // Serial chip select, active low
    input  wire logic        sdi,          // Serial data in
    output logic             sdo,          // Serial data out
    input  wire logic [7:0]  fuse_gain0,   // Fuse default for bank 0 gain
    input  wire logic [7:0]  fuse_gain1,   // Fuse default for bank 1 gain
    input  wire logic [7:0]  fuse_gain4,   // Fuse default for bank 4 gain
    input  wire logic [7:0]  fuse_gain5,   // Fuse default for bank 5 gain
    output logic             power_down,   // Device in power-down
    output logic             reset_busy,   // Full reset in progress
    output logic [7:0]       gain0,        // bank0_fine_gain value
    output logic [7:0]       gain1,        // bank1_fine_gain value
    output logic [7:0]       gain4,        // bank4_fine_gain value
    output logic [7:0]       gain5         // bank5_fine_gain value
);

    // Register storage
    logic [7:0]         setup_q, setup_d;     // interface_setup writable bits
    logic [7:0]         power_q, power_d;     // power_state
    logic [7:0]         class_q, class_d;     // device_class upper bits
    logic [7:0]         user_q,  user_d;      // user_config
    logic [7:0]         g0_q, g0_d;           // bank0_fine_gain
    logic [7:0]         g1_q, g1_d;           // bank1_fine_gain
    logic [7:0]         g4_q, g4_d;           // bank4_fine_gain
    logic [7:0]         g5_q, g5_d;           // bank5_fine_gain
    logic               fuse_q, fuse_d;       // Fuse load pending
    logic [SRST_W-1:0]  srst_q, srst_d;       // Full reset countdown
    logic [ADDR_W-1:0]  addr_q, addr_d;       // Current register address
    logic               read_q, read_d;       // Frame is a read
    logic               pwr_q, pwr_d;         // Registered power-down output

    // Shifter interface
    logic               hdr_valid;            // Header done
    logic               hdr_read;             // Header direction
    logic [ADDR_W-1:0]  hdr_addr;             // Header address
    logic               byte_valid;           // Byte done
    logic [7:0]         byte_data;            // Received byte
    logic [7:0]         rd_data;              // Read mux output
    logic               busy;                 // Full reset active

    assign busy       = (srst_q != '0);
    assign reset_busy = busy;
    assign power_down = pwr_q;
    assign gain0      = g0_q;
    assign gain1      = g1_q;
    assign gain4      = g4_q;
    assign gain5      = g5_q;

    // Read value of one register
    function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = BYTE_ZERO;
        unique case (a)
            OFS_SETUP: begin
                v = setup_q;
                v[SETUP_SDO_BIT] = 1'b1;
                v[SETUP_RST_BIT] = busy;
            end
            OFS_POWER: v = power_q;
            OFS_CLASS: v = {class_q[7:4], CLASS_CODE};
            OFS_USER:  v = user_q;
            OFS_GAIN0: v = g0_q;
            OFS_GAIN1: v = g1_q;
            OFS_GAIN4: v = g4_q;
            OFS_GAIN5: v = g5_q;
            default:   v = BYTE_ZERO;
        endcase
        return v;
    endfunction : read_reg

    // Next streaming address
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                    input logic hold,
                                                    input logic up);
        logic [ADDR_W-1:0] n;
        n = a;
        if (!hold) begin
            n = up ? a + ADDR_W'(1) : a - ADDR_W'(1);
        end
        return n;
    endfunction : step_addr

    // Read mux; a process so every register the function reads retriggers it
    always_comb begin
        rd_data = read_reg(addr_q);
    end

    // Serial framing
    scr_spi_shift u_shift (
        .clock      (clock),
        .rst_b      (rst_b),
        .clear      (busy),
        .sclk       (sclk),
        .cs_b       (cs_b),
        .sdi        (sdi),
        .sdo        (sdo),
        .hdr_valid  (hdr_valid),
        .hdr_read   (hdr_read),
        .hdr_addr   (hdr_addr),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .rd_data    (rd_data)
    );

    // Next register values
    always_comb begin
        setup_d = setup_q;
        power_d = power_q;
        class_d = class_q;
        user_d  = user_q;
        g0_d    = g0_q;
        g1_d    = g1_q;
        g4_d    = g4_q;
        g5_d    = g5_q;
        fuse_d  = fuse_q;
        srst_d  = srst_q;
        addr_d  = addr_q;
        read_d  = read_q;
        if (busy) begin
            // Hold all but the gain registers at reset values while the reset settles
            srst_d  = srst_q - SRST_W'(1);
            setup_d = SETUP_RESET & SETUP_RW_MASK;
            power_d = POWER_RESET;
            class_d = BYTE_ZERO;
            user_d  = BYTE_ZERO;
            fuse_d  = 1'b1;
            addr_d  = '0;
            read_d  = 1'b0;
        end else if (fuse_q) begin
            // Load gain defaults from fuses
            g0_d   = fuse_gain0;
            g1_d   = fuse_gain1;
            g4_d   = fuse_gain4;
            g5_d   = fuse_gain5;
            fuse_d = 1'b0;
        end else if (hdr_valid) begin
            // Start of a frame
            addr_d = hdr_addr;
            read_d = hdr_read;
        end else if (byte_valid) begin
            if (!read_q) begin
                // Write decode; fixed fields keep their values
                unique case (addr_q)
                    OFS_SETUP: begin
                        setup_d = byte_data & SETUP_RW_MASK;
                        if (byte_data[SETUP_RST_BIT]) begin
                            srst_d = SRST_W'(SRST_CYCLES);
                        end
                    end
                    OFS_POWER: power_d = byte_data;
                    OFS_CLASS: class_d = byte_data & CLASS_RW_MASK;
                    OFS_USER:  user_d  = byte_data;
                    OFS_GAIN0: g0_d    = byte_data;
                    OFS_GAIN1: g1_d    = byte_data;
                    OFS_GAIN4: g4_d    = byte_data;
                    OFS_GAIN5: g5_d    = byte_data;
                    default:   ;
                endcase
            end
            // Stream to the next address
            addr_d = step_addr(addr_q, user_q[USER_HOLD_BIT],
                               setup_q[SETUP_ASC_BIT]);
        end
    end

    // Power-down decode, reserved codes act as normal
    always_comb begin
        pwr_d = (power_d[1:0] == PWR_DOWN);
    end

    // Register bank flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            setup_q <= SETUP_RESET & SETUP_RW_MASK;
            power_q <= POWER_RESET;
            class_q <= BYTE_ZERO;
            user_q  <= BYTE_ZERO;
            g0_q    <= BYTE_ZERO;
            g1_q    <= BYTE_ZERO;
            g4_q    <= BYTE_ZERO;
            g5_q    <= BYTE_ZERO;
            fuse_q  <= 1'b1;
            srst_q  <= '0;
            addr_q  <= '0;
            read_q  <= 1'b0;
            pwr_q   <= 1'b0;
        end else begin
            setup_q <= setup_d;
            power_q <= power_d;
            class_q <= class_d;
            user_q  <= user_d;
            g0_q    <= g0_d;
            g1_q    <= g1_d;
            g4_q    <= g4_d;
            g5_q    <= g5_d;
            fuse_q  <= fuse_d;
            srst_q  <= srst_d;
            addr_q  <= addr_d;
            read_q  <= read_d;
            pwr_q   <= pwr_d;
        end
    end

endmodule : scr_regs
`default_nettype wire

// ===== scr_regs_sva.sv
// Checker for the serial configuration register bank.
// Assumes binding to scr_regs, sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module scr_regs_chk (
    input wire logic       clock,      // System clock
    input wire logic       rst_b,      // Reset, active low
    input wire logic       sclk,       // Serial clock
    input wire logic       cs_b,       // Select, active low
    input wire logic       sdo,        // Serial out
    input wire logic [7:0] fuse_gain0, // Fuse, bank 0
    input wire logic [7:0] fuse_gain5, // Fuse, bank 5
    input wire logic       power_down, // Power-down
    input wire logic       reset_busy, // Full reset busy
    input wire logic [7:0] gain0,      // Bank 0 gain
    input wire logic [7:0] gain5       // Bank 5 gain
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [2:0] quiet_q; // Idle cycles count
    logic [2:0] quiet_d; // Next idle count
    // Idle count, cleared by frames and resets
    always_comb begin
        quiet_d = quiet_q;
        if (!cs_b || reset_busy) quiet_d = 3'h0;
        else if (quiet_q != 3'h7) quiet_d = quiet_q + 3'h1;
    end
    // Idle count register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) quiet_q <= 3'h0;
        else quiet_q <= quiet_d;
    end
    sequence s_run; reset_busy [*8] ##1 !reset_busy; endsequence
    sequence s_deep; reset_busy ##1 reset_busy ##1 reset_busy; endsequence
    property p_len; $rose(reset_busy) |-> s_run; endproperty
    a_len: assert property (p_len) else $error("busy length");
    property p_start; $rose(reset_busy) |-> !$past(cs_b); endproperty
    a_start: assert property (p_start) else $error("busy start");
    property p_pd_busy; s_deep |-> !power_down; endproperty
    a_pd_busy: assert property (p_pd_busy) else $error("pd in reset");
    property p_pd_end; $fell(reset_busy) |-> !power_down; endproperty
    a_pd_end: assert property (p_pd_end) else $error("pd after reset");
    property p_reload;
        $fell(reset_busy) |-> ##[0:2] (gain0 == fuse_gain0 && gain5 == fuse_gain5);
    endproperty
    a_reload: assert property (p_reload) else $error("fuse reload");
    property p_pd_rise; $rose(power_down) |-> !cs_b; endproperty
    a_pd_rise: assert property (p_pd_rise) else $error("pd rise");
    property p_quiet;
        quiet_q >= 3'h4 |-> $stable(gain0) && $stable(gain5) && $stable(power_down);
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle change");
    property p_sdo;
        !cs_b && !$past(cs_b, 2) && !reset_busy && !$past(reset_busy) && $changed(sdo)
            |-> sclk && $past(sclk);
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo timing");
endmodule : scr_regs_chk
bind scr_regs scr_regs_chk i_chk (.clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .sdo(sdo), .fuse_gain0(fuse_gain0), .fuse_gain5(fuse_gain5), .power_down(power_down),
    .reset_busy(reset_busy), .gain0(gain0), .gain5(gain5));
`default_nettype wire

// ===== scr_spi_host.sv
// Serial host model, mode 0, four-wire.
// Assumes the bench clock at 10 MHz.
`timescale 1ns/10ps
`default_nettype none
module scr_spi_host (
    input  wire logic clock, // System clock
    output logic      sclk,  // Serial clock, low when idle
    output logic      cs_b,  // Select, active low
    output logic      sdi,   // Data to device
    input  wire logic sdo    // Data from device
);
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        sdi  = 1'b0;
    end
    // One frame; read bytes sampled on sdo at each rise
    task automatic xfer(input logic rd, input logic [14:0] adr, input int nb,
                        input logic [31:0] wd, output logic [31:0] rdat);
        logic [47:0] sh;
        sh = {rd, adr, wd};
        rdat = '0;
        @(posedge clock) #1 cs_b = 1'b0;
        for (int i = 0; i < 16 + 8 * nb; i++) begin
            sdi = sh[47 - i];
            repeat (4) @(posedge clock);
            #1 sclk = 1'b1;
            rdat = {rdat[30:0], sdo};
            repeat (4) @(posedge clock);
            #1 sclk = 1'b0;
        end
        repeat (4) @(posedge clock);
        #1 cs_b = 1'b1;
        sdi = ~sdi; // Released line shows no stale value
        repeat (2) @(posedge clock);
    endtask : xfer
endmodule : scr_spi_host
`default_nettype wire

// ===== test_spi_config_core_regs.sv
// Bench for the serial configuration register bank.
// Assumes the host model drives sclk, cs_b and sdi, and the device drives sdo.
`timescale 1ns/10ps
`default_nettype none
module test_spi_config_core_regs;
    import scr_pkg::*;
    localparam logic [3:0] CODE = 4'h9; // Class code, value arbitrary
    logic        clock, rst_b, sclk, cs_b, sdi, sdo, power_down, reset_busy, busy_seen;
    logic [7:0]  fuse_gain0, fuse_gain1, fuse_gain4, fuse_gain5, gain0, gain1, gain4, gain5;
    logic [7:0]  got, g5, v;          // Read byte, saved gain, power value
    logic [31:0] rdat, rnd;           // Host data, random word
    logic [22:0] exp_q[$];            // Address and expected read byte
    int          fail_count = 0;      // Mismatches
    int          total_checks = 0;    // Comparisons
    event        got_ev;              // Read result ready
    scr_regs #(.CLASS_CODE(CODE)) i_dut (.clock(clock), .rst_b(rst_b), .sclk(sclk),
        .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .fuse_gain0(fuse_gain0), .fuse_gain1(fuse_gain1),
        .fuse_gain4(fuse_gain4), .fuse_gain5(fuse_gain5), .power_down(power_down),
        .reset_busy(reset_busy), .gain0(gain0), .gain1(gain1), .gain4(gain4), .gain5(gain5));
    scr_spi_host i_host (.clock(clock), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));
    // Clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Note any full reset activity
    always @(posedge clock) if (reset_busy === 1'b1) busy_seen = 1'b1;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        repeat (2) @(posedge clock);      // Let the last read compare run
        if (exp_q.size() != 0) fail_count++; // A noted read never compared
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // Read one byte, expectation queued first
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        i_host.xfer(1'b1, a, 1, 32'h0000_0000, rdat);
        got = rdat[7:0];
        -> got_ev;
    endtask : rd
    task automatic wr(input logic [14:0] a, input int nb, input logic [31:0] d);
        i_host.xfer(1'b0, a, nb, d, rdat);
    endtask : wr
    // Compare each read with the oldest note
    always @(got_ev) begin
        logic [22:0] n;
        n = exp_q.pop_front();
        check($sformatf("reg %h", n[22:8]), got, n[7:0]);
    end
    // Defaults after any reset
    task automatic defaults();
        rd(OFS_SETUP, 8'h30);
        rd(OFS_POWER, 8'h00);
        rd(OFS_USER, 8'h00);
        rd(OFS_CLASS, {4'h0, CODE});
        rd(OFS_GAIN0, fuse_gain0);
        check("gain5", gain5, fuse_gain5);
        check("pd", {7'h00, power_down}, 8'h00);
    endtask : defaults
    initial begin
        rnd = $urandom(53353);
        {fuse_gain0, fuse_gain1, fuse_gain4, fuse_gain5} = $urandom;
        rst_b = 1'b0;
        busy_seen = 1'b0;
        repeat (4) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clock);
        defaults();
        wr(OFS_CLASS, 1, 32'hFF00_0000);
        rd(OFS_CLASS, {4'hF, CODE});
        wr(OFS_SETUP, 1, 32'h4F00_0000);
        rd(OFS_SETUP, 8'h5F);
        // Every power code
        for (int c = 0; c < 4; c++) begin
            v = {6'($urandom_range(63, 0)), c[1:0]};
            wr(OFS_POWER, 1, {v, 24'h00_0000});
            check("pd", {7'h00, power_down}, {7'h00, c == 3});
            rd(OFS_POWER, v);
        end
        // Streaming down then up
        for (int d = 0; d < 2; d++) begin
            wr(OFS_SETUP, 1, {2'b00, d[0], 5'h00, 24'h00_0000});
            rnd = $urandom;
            wr(d ? OFS_GAIN0 : OFS_GAIN5, 2, rnd);
            if (d == 0) g5 = rnd[31:24];
            check("first", d ? gain0 : gain5, rnd[31:24]);
            check("second", d ? gain1 : gain4, rnd[23:16]);
        end
        // Address hold keeps both bytes on one place
        wr(OFS_USER, 1, 32'h0100_0000);
        rnd = $urandom;
        wr(OFS_GAIN4, 2, rnd);
        check("held", gain4, rnd[23:16]);
        check("next", gain5, g5);
        // Full reset, then settle time before traffic
        wr(OFS_SETUP, 1, 32'h8000_0000);
        for (int n = 0; reset_busy !== 1'b0; n++) begin
            if (n > 20) begin
                fail_count++;
                finish_test();
            end
            @(posedge clock);
        end
        repeat (10) @(posedge clock);
        check("busy", {7'h00, busy_seen}, 8'h01);
        defaults();
        finish_test();
    end
endmodule : test_spi_config_core_regs
`default_nettype wire
